//--- sim/mailbox_buffer_management_bench.sv
// Self-checking bench driving mailbox messages over Wishbone
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module mailbox_buffer_management_bench;
    import mbm_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [3:0] tx_space_ok = 4'h0;
    logic [3:0] formatter_configured = 4'h0;
    logic rx_word_valid = 1'b0;
    logic [1:0] rx_word_path = 2'h0;
    logic rx_word_end = 1'b0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, rx_msg_done, response_ready;
    logic [3:0] rx_clear, tx_clear;
    logic [1:0] rx_msg_path, dn_path;
    logic [7:0] rx_msg_len, dn_len;
    logic [3:0][15:0] rx_free_bytes, tx_free_bytes;
    logic [3:0][7:0] rx_message_count, tx_message_count;
    int failures = 0;
    int checks_done = 0;
    int dn_cnt = 0;
    always #4 ref_clk = ~ref_clk;
    mbm_core u_mbm_core (.ref_clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i(4'hf),
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_free_bytes, .rx_message_count,
        .tx_free_bytes, .tx_message_count, .tx_space_ok, .formatter_configured, .rx_word_valid,
        .rx_word_path, .rx_word_end, .rx_clear, .tx_clear, .rx_msg_done, .rx_msg_path,
        .rx_msg_len, .response_ready);
    mbm_buf_model u_mbm_buf_model (.ref_clk, .sys_rst, .rx_clear, .tx_clear, .rx_free_bytes,
        .rx_message_count, .tx_free_bytes, .tx_message_count);
    always @(posedge ref_clk) begin
        if (rx_msg_done === 1'b1) begin
            dn_len <= rx_msg_len;
            dn_path <= rx_msg_path;
            dn_cnt <= dn_cnt + 1;
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Holds the request until the edge that samples ack, then idles one cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            failures++;
            end_sim();
        end
        @(posedge ref_clk);
    endtask
    task automatic msg(input logic [7:0] h, input logic [7:0] hi);
        bus(1'b1, OFS_HOST_HDR, h);
        bus(1'b1, OFS_CTRL_HI, hi);
        bus(1'b1, OFS_CTRL_LO, 8'h00);
        bus(1'b1, OFS_CMD, 8'h01);
    endtask
    task automatic rsp(input logic [7:0] h, input logic [7:0] hi, input logic [7:0] lo,
                       input logic [47:0] v);
        int n;
        n = 0;
        while (response_ready !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK("response_ready", 1'b1, response_ready)
        bus(1'b0, OFS_DEV_HDR, 8'h00);
        `CHK("device_message_header", h, q[7:0])
        bus(1'b0, OFS_CTRL_HI, 8'h00);
        `CHK("message_control_high", hi, q[7:0])
        bus(1'b0, OFS_CTRL_LO, 8'h00);
        `CHK("message_control_low", lo, q[7:0])
        for (int i = 0; i < 6 && lo != 8'h00; i++) begin
            bus(1'b0, OFS_PARAM0 + 8'(4 * i), 8'h00);
            `CHK("parameter", v[47 - 8 * i -: 8], q[7:0])
        end
        bus(1'b1, OFS_CMD, 8'h02);
    endtask
    task automatic cfg(input logic [1:0] p, input logic [7:0] len);
        logic z;
        z = (p == 2'h0);
        msg({p, z ? MSC_CFG_REQ_P0 : MSC_CFG_REQ_PN, 2'b00}, 8'h00);
        rsp({p, z ? 4'hf : 4'h9, 2'b00}, {5'h0, z ? 3'h5 : 3'h4}, 8'h02,
            {len, z ? 8'd61 : 8'd253, 32'h0});
    endtask
    task automatic sts(input logic [1:0] p, input logic [3:0] rdm);
        logic z;
        z = (p == 2'h0);
        msg({p, z ? MSC_STS_REQ_P0 : MSC_STS_REQ_PN, z ? 2'b01 : 2'b00}, 8'h00);
        rsp({p, z ? 4'hf : 4'hb, z ? 2'b01 : 2'b00}, {4'h0, rdm}, 8'h06,
            {rx_free_bytes[p][7:0], rx_free_bytes[p][15:8], rx_message_count[p],
             tx_free_bytes[p][7:0], tx_free_bytes[p][15:8], tx_message_count[p]});
    endtask
    task automatic ctl(input logic [1:0] p, input logic [1:0] s, input logic [7:0] e);
        logic [7:0] seen;
        seen = 8'h00;
        msg({p, MSC_CTL_CMD, p == 2'h0 ? MDS_CTL_P0 : MDS_PN}, {6'h0, s});
        // The pulse stands in the edge at which the last bus call returns
        repeat (8) begin
            seen = seen | {rx_clear, tx_clear};
            @(posedge ref_clk);
        end
        `CHK("clear pulses", e, seen)
    endtask
    task automatic words(input logic [1:0] p, input int n, input logic e);
        for (int i = 1; i <= n; i++) begin
            rx_word_valid <= 1'b1;
            rx_word_path <= p;
            rx_word_end <= e && i == n;
            @(posedge ref_clk);
        end
        rx_word_valid <= 1'b0;
        rx_word_end <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("response_ready", 1'b0, response_ready)
        bus(1'b1, 8'h30, 8'h5a);
        bus(1'b0, 8'h30, 8'h00);
        `CHK("unmapped read", 8'h00, q[7:0])
        bus(1'b1, OFS_HOST_HDR, 8'ha5);
        bus(1'b0, OFS_HOST_HDR, 8'h00);
        `CHK("host_message_header", 8'ha5, q[7:0])
        for (int p = 0; p < 4; p++) cfg(2'(p), 8'd32);
        for (int p = 0; p < 4; p++) sts(2'(p), 4'h0);
        msg({2'b01, 4'he, 2'b00}, 8'h00);
        repeat (10) @(posedge ref_clk);
        `CHK("response_ready", 1'b0, response_ready)
        bus(1'b0, OFS_CMD, 8'h00);
        `CHK("ignored flag", 8'h04, q[7:0])
        ctl(2'h2, 2'b00, 8'h40);
        ctl(2'h0, 2'b01, 8'h01);
        ctl(2'h3, 2'b10, 8'h88);
        ctl(2'h1, 2'b11, 8'h00);
        bus(1'b0, OFS_CMD, 8'h00);
        `CHK("ignored flag", 8'h04, q[7:0])
        sts(2'h2, 4'h0);
        cfg(2'h2, 8'd32);
        cfg(2'h3, 8'd32);
        words(2'h1, 32, 1'b0);
        `CHK("rx_msg_len", 8'd32, dn_len)
        `CHK("rx_msg_path", 2'h1, dn_path)
        words(2'h3, 5, 1'b1);
        `CHK("rx_msg_len", 8'd5, dn_len)
        `CHK("rx_msg_done count", 2, dn_cnt)
        tx_space_ok <= 4'b0101;
        formatter_configured <= 4'b1000;
        @(posedge ref_clk);
        formatter_configured <= 4'h0;
        rsp(8'h00, 8'h0d, 8'h00, 48'h0);
        sts(2'h1, 4'b0101);
        msg({2'b01, MSC_STS_REQ_PN, 2'b00}, 8'h01);
        rsp(8'h00, 8'h02, 8'h00, 48'h0);
        repeat (20) @(posedge ref_clk);
        `CHK("response_ready", 1'b0, response_ready)
        end_sim();
    end
endmodule
`default_nettype wire

//--- sim/mbm_buf_model.sv
// Behavioural model of the per-path buffers behind the block
`timescale 1ns/1ps
`default_nettype none
module mbm_buf_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [3:0] rx_clear,
    input wire logic [3:0] tx_clear,
    output logic [3:0][15:0] rx_free_bytes,
    output logic [3:0][7:0] rx_message_count,
    output logic [3:0][15:0] tx_free_bytes,
    output logic [3:0][7:0] tx_message_count
);
    // Partly filled at start, so a clear shows as a change in the counts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        for (int p = 0; p < 4; p++) begin
            if (sys_rst) begin
                rx_free_bytes[p] <= 16'h0a10 + 16'(p);
                rx_message_count[p] <= 8'h03 + 8'(p);
                tx_free_bytes[p] <= 16'h0b20 + 16'(p);
                tx_message_count[p] <= 8'h05 + 8'(p);
            end else begin
                if (rx_clear[p]) begin
                    rx_free_bytes[p] <= 16'h0c00;
                    rx_message_count[p] <= 8'h00;
                end
                if (tx_clear[p]) begin
                    tx_free_bytes[p] <= 16'h0c00;
                    tx_message_count[p] <= 8'h00;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/mbm_core_chk.sv
// Port-level assertions for the mailbox buffer management block
`timescale 1ns/1ps
`default_nettype none
module mbm_core_chk (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [3:0] rx_clear,
    input wire logic [3:0] tx_clear,
    input wire logic rx_word_valid,
    input wire logic rx_msg_done,
    input wire logic [7:0] rx_msg_len,
    input wire logic response_ready
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_clear_onehot: assert property ($onehot0(rx_clear) && $onehot0(tx_clear))
        else $error("clear pulse names more than one path");
    a_clear_pulse: assert property ((rx_clear | tx_clear) != 4'h0 |=>
        (rx_clear | tx_clear) == 4'h0)
        else $error("clear pulse longer than one cycle");
    a_done_cause: assert property (rx_msg_done |-> $past(rx_word_valid))
        else $error("message done without a preceding word");
    a_done_len: assert property (rx_msg_done |->
        rx_msg_len != 8'h0 && rx_msg_len <= 8'h20)
        else $error("message length outside one to configured maximum");
    c_clear: cover property (rx_clear != 4'h0 && tx_clear != 4'h0);
    c_done_full: cover property (rx_msg_done && rx_msg_len == 8'h20);
    c_response: cover property ($rose(response_ready));
endmodule
bind mbm_core mbm_core_chk u_mbm_core_chk (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .rx_clear, .tx_clear, .rx_word_valid, .rx_msg_done,
    .rx_msg_len, .response_ready);
`default_nettype wire

//--- src/mbm_core.sv
// Mailbox buffer management command interpreter with Wishbone register access
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module mbm_core (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [3:0][15:0] rx_free_bytes,
    input wire logic [3:0][7:0] rx_message_count,
    input wire logic [3:0][15:0] tx_free_bytes,
    input wire logic [3:0][7:0] tx_message_count,
    input wire logic [3:0] tx_space_ok,
    input wire logic [3:0] formatter_configured,
    input wire logic rx_word_valid,
    input wire logic [1:0] rx_word_path,
    input wire logic rx_word_end,
    output logic [3:0] rx_clear,
    output logic [3:0] tx_clear,
    output logic rx_msg_done,
    output logic [1:0] rx_msg_path,
    output logic [7:0] rx_msg_len,
    output logic response_ready
);
    import mbm_pkg::*;

    logic [7:0] host_message_header;
    logic [7:0] message_control_high;
    logic [7:0] message_control_low;
    logic [7:0] device_message_header;
    logic [7:0] rsp_ctrl_high;
    logic [7:0] rsp_ctrl_low;
    logic [7:0] rsp_param [0:RSP_PARAMS-1];
    logic cmd_pending;
    logic [2:0] base_priority [0:3];
    logic [7:0] max_message_length [0:3];
    logic [3:0] ind_pending;
    logic [3:0] tx_space_q;
    logic [7:0] path_fill_next [0:3];
    logic [3:0] path_flush;
    logic cmd_ignored;
    logic [31:0] next_rd;
    mbm_rsp_t next_rsp;

    // Bus decode
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr_byte = wb_req & wb_we_i & wb_sel_i[0];
    wire wr_host_hdr = wr_byte & (wb_adr_i == OFS_HOST_HDR);
    wire wr_ctrl_hi = wr_byte & (wb_adr_i == OFS_CTRL_HI);
    wire wr_ctrl_lo = wr_byte & (wb_adr_i == OFS_CTRL_LO);
    wire wr_cmd = wr_byte & (wb_adr_i == OFS_CMD);
    wire cmd_go = wr_cmd & wb_dat_i[CMD_GO_BIT];
    wire rsp_taken = wr_cmd & wb_dat_i[CMD_DONE_BIT];
    wire [7:0] param_off = wb_adr_i - OFS_PARAM0;
    wire param_hit = (param_off < PARAM_SPAN) && (param_off[1:0] == 2'h0);
    wire [2:0] param_idx = param_off[4:2];

    // Header fields of the pending host message
    wire [1:0] datapath_selector = host_message_header[HDR_PATH_LSB +: 2];
    wire [3:0] message_code = host_message_header[HDR_CODE_LSB +: 4];
    wire [1:0] destination_source_field = host_message_header[HDR_MDS_LSB +: 2];
    wire path0 = (datapath_selector == 2'h0);
    wire [1:0] clear_reset_select = message_control_high[1:0];
    wire status_type_bit = message_control_high[0];
    wire [3:0] path_onehot = 4'h1 << datapath_selector;

    // Message classification; anything else falls through unused
    wire is_cfg_req = path0 ?
        (message_code == MSC_CFG_REQ_P0) && (destination_source_field == MDS_CFG_P0) :
        (message_code == MSC_CFG_REQ_PN) && (destination_source_field == MDS_PN);
    wire is_sts_req = path0 ?
        (message_code == MSC_STS_REQ_P0) && (destination_source_field == MDS_STS_P0) :
        (message_code == MSC_STS_REQ_PN) && (destination_source_field == MDS_PN);
    wire ctl_mds_ok = destination_source_field == (path0 ? MDS_CTL_P0 : MDS_PN);
    wire is_ctl_cmd = (message_code == MSC_CTL_CMD) && ctl_mds_ok &&
        (clear_reset_select != 2'h3);

    // Control commands need no mailbox slot and act at once
    wire exec = cmd_pending & (is_ctl_cmd | ~response_ready);
    wire do_cfg = exec & is_cfg_req;
    wire do_sts = exec & is_sts_req & ~status_type_bit;
    wire do_force = exec & is_sts_req & status_type_bit;
    wire do_ctl = exec & is_ctl_cmd;
    wire do_ind = ~response_ready & ~cmd_pending & (ind_pending != 4'h0);
    wire do_clr_rx = do_ctl & (clear_reset_select != CRB_CLR_TX);
    wire do_clr_tx = do_ctl & (clear_reset_select != CRB_CLR_RX);
    wire do_reset = do_ctl & (clear_reset_select == CRB_RESET);

    // New space transitions and freshly configured formatters raise requests
    wire [3:0] tx_rise = tx_space_ok & ~tx_space_q;
    wire [3:0] ind_claim = (do_ind | do_force) ? ind_pending : 4'h0;
    wire [3:0] next_ind_pending = (ind_pending & ~ind_claim) | tx_rise |
        formatter_configured;
    wire next_response_ready = do_cfg | do_sts | do_force | do_ind |
        (response_ready & ~rsp_taken);
    wire next_cmd_pending = cmd_go | (cmd_pending & ~exec);

    // Unknown messages are consumed; the flag tells software why nothing came back
    wire cmd_known = is_cfg_req | is_sts_req | is_ctl_cmd;
    wire next_cmd_ignored = (exec & ~cmd_known) | (cmd_ignored & ~cmd_go);

    // Receive accumulation, one counter per path; only the word's own path moves
    wire [7:0] rx_cnt_inc = path_fill_next[rx_word_path];
    wire rx_flush = |path_flush;

    // Per-path settings and receive counters
    for (genvar p = 0; p < 4; p++) begin : g_path
        wire path_hit = (datapath_selector == 2'(p));
        mbm_path_cfg #(
            .RST_PRIO((p == 0) ? BBP_RST_P0 : BBP_RST_PN)
        ) u_mbm_path_cfg (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .restore(do_reset & path_hit),
            .prio(base_priority[p]),
            .max_len(max_message_length[p])
        );
        mbm_rx_path u_mbm_rx_path (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .word_valid(rx_word_valid & (rx_word_path == 2'(p))),
            .word_end(rx_word_end),
            .clear(do_clr_rx & path_hit),
            .max_len(max_message_length[p]),
            .flush(path_flush[p]),
            .fill_next(path_fill_next[p])
        );
    end

    // Reply fields, picked by the response kind below
    wire [3:0] cfg_code = path0 ? MSC_CFG_RSP_P0 : MSC_CFG_RSP_PN;
    wire [3:0] sts_code = path0 ? MSC_STS_RSP_P0 : MSC_STS_RSP_PN;
    wire [1:0] sts_src = path0 ? MDS_STS_P0 : MDS_PN;
    wire [7:0] path_mpl = path0 ? MPL_P0 : MPL_PN;
    wire [3:0] ind_bits = ind_pending | (do_force ? path_onehot : 4'h0);

    always_comb begin
        next_rsp = MBM_RSP_NONE;
        if (do_cfg) begin
            next_rsp = MBM_RSP_CFG;
        end else if (do_sts) begin
            next_rsp = MBM_RSP_STS;
        end else if (do_force | do_ind) begin
            next_rsp = MBM_RSP_IND;
        end
    end

    always_comb begin
        next_rd = 32'h0;
        case (wb_adr_i)
            OFS_HOST_HDR: next_rd = {24'h0, host_message_header};
            OFS_CTRL_HI: next_rd = {24'h0, rsp_ctrl_high};
            OFS_CTRL_LO: next_rd = {24'h0, rsp_ctrl_low};
            OFS_CMD: next_rd = {29'h0, cmd_ignored, cmd_pending, response_ready};
            OFS_DEV_HDR: next_rd = {24'h0, device_message_header};
            default: next_rd = param_hit ? {24'h0, rsp_param[param_idx]} : 32'h0;
        endcase
    end

    // Bus slave: one registered answer in the cycle after the request, unmapped reads give zero
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? next_rd : 32'h0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_message_header <= 8'h0;
            message_control_high <= 8'h0;
            message_control_low <= 8'h0;
        end else begin
            if (wr_host_hdr) begin
                host_message_header <= wb_dat_i[7:0];
            end
            if (wr_ctrl_hi) begin
                message_control_high <= wb_dat_i[7:0];
            end
            if (wr_ctrl_lo) begin
                message_control_low <= wb_dat_i[7:0];
            end
        end
    end

    // A new arrival beats the clear in the same cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_pending <= 1'b0;
            response_ready <= 1'b0;
            ind_pending <= 4'h0;
            tx_space_q <= 4'h0;
            cmd_ignored <= 1'b0;
        end else begin
            cmd_pending <= next_cmd_pending;
            response_ready <= next_response_ready;
            ind_pending <= next_ind_pending;
            tx_space_q <= tx_space_ok;
            cmd_ignored <= next_cmd_ignored;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_clear <= 4'h0;
            tx_clear <= 4'h0;
        end else begin
            rx_clear <= do_clr_rx ? path_onehot : 4'h0;
            tx_clear <= do_clr_tx ? path_onehot : 4'h0;
        end
    end

    // Response assembly into the device-side mailbox registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            device_message_header <= 8'h0;
            rsp_ctrl_high <= 8'h0;
            rsp_ctrl_low <= 8'h0;
            for (int i = 0; i < RSP_PARAMS; i++) begin
                rsp_param[i] <= 8'h0;
            end
        end else begin
            case (next_rsp)
                MBM_RSP_CFG: begin
                    device_message_header <= {datapath_selector, cfg_code, MDS_PN};
                    rsp_ctrl_high <= {5'h0, base_priority[datapath_selector]};
                    rsp_ctrl_low <= CFG_PARAM_CNT;
                    rsp_param[0] <= max_message_length[datapath_selector];
                    rsp_param[1] <= path_mpl;
                    for (int i = 2; i < RSP_PARAMS; i++) begin
                        rsp_param[i] <= 8'h0;
                    end
                end
                MBM_RSP_STS: begin
                    device_message_header <= {datapath_selector, sts_code, sts_src};
                    rsp_ctrl_high <= {4'h0, tx_space_ok};
                    rsp_ctrl_low <= STS_PARAM_CNT;
                    rsp_param[0] <= rx_free_bytes[datapath_selector][7:0];
                    rsp_param[1] <= rx_free_bytes[datapath_selector][15:8];
                    rsp_param[2] <= rx_message_count[datapath_selector];
                    rsp_param[3] <= tx_free_bytes[datapath_selector][7:0];
                    rsp_param[4] <= tx_free_bytes[datapath_selector][15:8];
                    rsp_param[5] <= tx_message_count[datapath_selector];
                end
                MBM_RSP_IND: begin
                    // Forced entry adds the selected path even without a transition
                    device_message_header <= 8'h0;
                    rsp_ctrl_high <= {4'h0, ind_bits};
                    rsp_ctrl_low <= 8'h0;
                    for (int i = 0; i < RSP_PARAMS; i++) begin
                        rsp_param[i] <= 8'h0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Shorter messages leave early on frame end
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_msg_done <= 1'b0;
            rx_msg_path <= 2'h0;
            rx_msg_len <= 8'h0;
        end else begin
            rx_msg_done <= rx_flush;
            if (rx_word_valid) begin
                rx_msg_path <= rx_word_path;
                rx_msg_len <= rx_cnt_inc;
            end
        end
    end
endmodule

// Settings of one path; only the reset command touches them
module mbm_path_cfg #(
    parameter logic [2:0] RST_PRIO = mbm_pkg::BBP_RST_PN
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic restore,
    output logic [2:0] prio,
    output logic [7:0] max_len
);
    import mbm_pkg::*;

    // Buffer clears never reach here, so settings outlive them
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prio <= RST_PRIO;
            max_len <= MML_RST;
        end else if (restore) begin
            prio <= RST_PRIO;
            max_len <= MML_RST;
        end
    end
endmodule

// One receive fill counter; a clear beats a word in the same cycle
module mbm_rx_path (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic word_valid,
    input wire logic word_end,
    input wire logic clear,
    input wire logic [7:0] max_len,
    output logic flush,
    output logic [7:0] fill_next
);
    logic [7:0] fill;

    assign fill_next = 8'(fill + 8'h01);
    // Greater-or-equal also closes a message if the length shrank under a partial fill
    assign flush = word_valid & (word_end | (fill_next >= max_len));

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill <= 8'h0;
        end else if (clear) begin
            fill <= 8'h0;
        end else if (word_valid) begin
            fill <= flush ? 8'h0 : fill_next;
        end
    end
endmodule

`default_nettype wire

//--- src/mbm_pkg.sv
// Constants and types shared by the mailbox buffer management block
package mbm_pkg;
    // Wishbone register byte offsets
    localparam logic [7:0] OFS_HOST_HDR = 8'h00;
    localparam logic [7:0] OFS_CTRL_HI = 8'h04;
    localparam logic [7:0] OFS_CTRL_LO = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_DEV_HDR = 8'h10;
    localparam logic [7:0] OFS_PARAM0 = 8'h14;
    localparam logic [7:0] PARAM_SPAN = 8'h18;
    localparam int RSP_PARAMS = 6;

    // Command register bits
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_DONE_BIT = 1;
    localparam int STAT_RSP_BIT = 0;
    localparam int STAT_PEND_BIT = 1;

    // Header layout
    localparam int HDR_PATH_LSB = 6;
    localparam int HDR_CODE_LSB = 2;
    localparam int HDR_MDS_LSB = 0;

    // Message codes
    localparam logic [3:0] MSC_CFG_REQ_P0 = 4'h7;
    localparam logic [3:0] MSC_CFG_REQ_PN = 4'h1;
    localparam logic [3:0] MSC_CFG_RSP_P0 = 4'hf;
    localparam logic [3:0] MSC_CFG_RSP_PN = 4'h9;
    localparam logic [3:0] MSC_STS_REQ_P0 = 4'h7;
    localparam logic [3:0] MSC_STS_REQ_PN = 4'h3;
    localparam logic [3:0] MSC_STS_RSP_P0 = 4'hf;
    localparam logic [3:0] MSC_STS_RSP_PN = 4'hb;
    localparam logic [3:0] MSC_CTL_CMD = 4'h2;

    // Destination / source codes
    localparam logic [1:0] MDS_CFG_P0 = 2'h0;
    localparam logic [1:0] MDS_STS_P0 = 2'h1;
    localparam logic [1:0] MDS_CTL_P0 = 2'h2;
    localparam logic [1:0] MDS_PN = 2'h0;

    // Clear / reset select codes
    localparam logic [1:0] CRB_CLR_RX = 2'h0;
    localparam logic [1:0] CRB_CLR_TX = 2'h1;
    localparam logic [1:0] CRB_RESET = 2'h2;

    // Reset values and limits
    localparam logic [2:0] BBP_RST_P0 = 3'h5;
    localparam logic [2:0] BBP_RST_PN = 3'h4;
    localparam logic [7:0] MML_RST = 8'h20;
    localparam logic [7:0] MPL_P0 = 8'h3d;
    localparam logic [7:0] MPL_PN = 8'hfd;
    localparam logic [7:0] CFG_PARAM_CNT = 8'h02;
    localparam logic [7:0] STS_PARAM_CNT = 8'h06;

    typedef enum logic [1:0] {
        MBM_RSP_NONE,
        MBM_RSP_CFG,
        MBM_RSP_STS,
        MBM_RSP_IND
    } mbm_rsp_t;
endpackage
